/* shared/vofr_regs.vh */
/*
 * Constants for the output overvoltage fault response block: command
 * codes, register field positions, reset values and timing figures.
 * Assumes it is included by bare name from design files of this block.
 */
// Overview of operation
// - Top three format bits pick linear, VID or direct output format.
// - Low five format bits: exponent, VID code, or zero in direct.
// - Conversion does not start until input voltage reaches turn-on level; timed restarts do not check it.
// - Overvoltage flag rises only when output is strictly above limit.
// - Overvoltage limit is unsigned mantissa with fixed exponent -5.
// - Restart starts spaced by response bits 2:0 times 200 ms.
// - Response 00 keeps the output running through an overvoltage.
// - Response 10 disables output and follows retry count in bits 5:3.
// - Retry count 000: no restart, output off until fault cleared.
// - Codes 001..110 allow that many restarts, then stay off.
// - Code 111 retries forever until off command, bias loss, other fault.
// - Clear-faults command clears latched flags and frees held output.

`ifndef VOFR_REGS_VH
`define VOFR_REGS_VH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define VOFR_CMD_CLEAR_FAULTS  8'h03
`define VOFR_CMD_OUT_FORMAT    8'h20
`define VOFR_CMD_TURN_ON       8'h35
`define VOFR_CMD_OV_LIMIT      8'h40
`define VOFR_CMD_OV_ACTION     8'h41

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define VOFR_FMT_MODE_HI       7
`define VOFR_FMT_MODE_LO       5
`define VOFR_FMT_PARAM_HI      4
`define VOFR_FMT_PARAM_LO      0
`define VOFR_ACT_RESP_HI       7
`define VOFR_ACT_RESP_LO       6
`define VOFR_ACT_RETRY_HI      5
`define VOFR_ACT_RETRY_LO      3
`define VOFR_ACT_DELAY_HI      2
`define VOFR_ACT_DELAY_LO      0

// ----------------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------------
`define VOFR_MODE_LINEAR       3'h0
`define VOFR_MODE_VID          3'h1
`define VOFR_MODE_DIRECT       3'h2
`define VOFR_RESP_IGNORE       2'h0
`define VOFR_RESP_DISABLE      2'h2
`define VOFR_RETRY_NONE        3'h0
`define VOFR_RETRY_FOREVER     3'h7
`define VOFR_PARAM_ZERO        5'h00

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define VOFR_RST_OUT_FORMAT    8'h00
`define VOFR_RST_TURN_ON       16'h0000
`define VOFR_RST_OV_LIMIT      16'hffff
`define VOFR_RST_OV_ACTION     8'h80

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define VOFR_UNIT_MS           200
`define VOFR_CLK_KHZ           50000

`endif

/* design/vofr_unit_timer.v */
/*
 * Prescaler that turns the system clock into one-cycle delay-unit ticks.
 * Assumes a single clock; clear_i restarts a whole unit from zero.
 */
`timescale 1ns/1ps

module vofr_unit_timer #(
   parameter UNIT_CYCLES = 10000000,
   parameter CNT_W       = 24
) (
   input  wire clock_i,
   input  wire reset_i,
   input  wire clear_i,
   output reg  tick_o
);

   // Cut the full-width count down to the counter width on purpose
   localparam [31:0]      LAST_FULL = UNIT_CYCLES - 1;
   localparam [CNT_W-1:0] LAST      = LAST_FULL[CNT_W-1:0];

   reg [CNT_W-1:0] count_reg;

   // Count whole units; a clear makes the next unit a full one
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         count_reg <= {CNT_W{1'b0}};
         tick_o    <= 1'b0;
      end else if (clear_i) begin
         count_reg <= {CNT_W{1'b0}};
         tick_o    <= 1'b0;
      end else if (count_reg == LAST) begin
         count_reg <= {CNT_W{1'b0}};
         tick_o    <= 1'b1;
      end else begin
         count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
         tick_o    <= 1'b0;
      end
   end

endmodule

/* design/vofr_core.v */
/*
 * Output format selector, input turn-on gate, output overvoltage limit
 * and the overvoltage fault response machine with timed restarts.
 * Assumes a command decoder on the same clock hands over decoded
 * commands, and that measurements and the on/off request are also
 * produced on this clock. Bias loss is seen as reset_i.
 */
`timescale 1ns/1ps
`include "vofr_regs.vh"

module vofr_core #(
   parameter UNIT_CYCLES = `VOFR_UNIT_MS * `VOFR_CLK_KHZ,
   parameter CNT_W       = 24
) (
   input  wire        clock_i,
   input  wire        reset_i,
   input  wire        cmd_valid_i,
   input  wire        cmd_write_i,
   input  wire [7:0]  cmd_code_i,
   input  wire [15:0] cmd_wdata_i,
   input  wire [15:0] vin_meas_i,
   input  wire [15:0] vout_meas_i,
   input  wire        on_request_i,
   input  wire        other_fault_i,
   output reg  [15:0] rdata_o,
   output reg         rvalid_o,
   output reg         output_enable_o,
   output reg         ov_fault_o,
   output reg         off_latched_o,
   output reg  [2:0]  format_mode_o,
   output reg  [4:0]  format_param_o,
   output reg  [2:0]  restarts_used_o
);

   // -------------------------------------------------------------------
   // States
   // -------------------------------------------------------------------
   localparam [1:0] ST_OFF   = 2'h0;
   localparam [1:0] ST_RUN   = 2'h1;
   localparam [1:0] ST_WAIT  = 2'h2;
   localparam [1:0] ST_LATCH = 2'h3;

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   reg  [7:0]  out_format_reg;
   reg  [15:0] turn_on_reg;
   reg  [15:0] ov_limit_reg;
   reg  [7:0]  ov_action_reg;
   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg  [2:0]  used_reg;
   reg  [2:0]  used_next;
   reg  [2:0]  delay_reg;
   reg  [2:0]  delay_next;
   reg  [2:0]  units_reg;
   reg  [2:0]  units_next;
   reg         timer_clear;
   reg  [15:0] read_mux;
   wire        unit_tick;
   wire        wr_cmd;
   wire        clear_cmd;
   wire        ov_now;
   wire        vin_ready;
   wire [1:0]  resp;
   wire [2:0]  retries;
   wire [2:0]  delay_code;

   // Map the mode field onto the parameter field meaning
   function [4:0] fmt_param;
      input [7:0] fmt;
      begin
         if (fmt[`VOFR_FMT_MODE_HI:`VOFR_FMT_MODE_LO] == `VOFR_MODE_DIRECT)
            fmt_param = `VOFR_PARAM_ZERO;
         else
            fmt_param = fmt[`VOFR_FMT_PARAM_HI:`VOFR_FMT_PARAM_LO];
      end
   endfunction

   // -------------------------------------------------------------------
   // Command decode
   // -------------------------------------------------------------------
   // Reads never change state; only writes decode into actions
   assign wr_cmd    = cmd_valid_i & cmd_write_i;
   assign clear_cmd = wr_cmd & (cmd_code_i == `VOFR_CMD_CLEAR_FAULTS);

   // Field views of the response register
   assign resp       = ov_action_reg[`VOFR_ACT_RESP_HI:`VOFR_ACT_RESP_LO];
   assign retries    = ov_action_reg[`VOFR_ACT_RETRY_HI:`VOFR_ACT_RETRY_LO];
   assign delay_code = ov_action_reg[`VOFR_ACT_DELAY_HI:`VOFR_ACT_DELAY_LO];

   // Both values share exponent -5 so mantissas compare directly;
   // equality is a pass, the limit resolution sets the real trip level
   assign ov_now = (vout_meas_i > ov_limit_reg);

   // Threshold and measurement share exponent -3, so compare mantissas
   assign vin_ready = (vin_meas_i >= turn_on_reg);

   // -------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------
   // Writes land at the taking edge; unknown codes leave every register
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         out_format_reg <= `VOFR_RST_OUT_FORMAT;
         turn_on_reg    <= `VOFR_RST_TURN_ON;
         ov_limit_reg   <= `VOFR_RST_OV_LIMIT;
         ov_action_reg  <= `VOFR_RST_OV_ACTION;
      end else if (wr_cmd) begin
         case (cmd_code_i)
            `VOFR_CMD_OUT_FORMAT: begin
               out_format_reg <= cmd_wdata_i[7:0];
            end
            `VOFR_CMD_TURN_ON: begin
               turn_on_reg <= cmd_wdata_i;
            end
            `VOFR_CMD_OV_LIMIT: begin
               ov_limit_reg <= cmd_wdata_i;
            end
            `VOFR_CMD_OV_ACTION: begin
               ov_action_reg <= cmd_wdata_i[7:0];
            end
            default: begin
               out_format_reg <= out_format_reg;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Read-back
   // -------------------------------------------------------------------
   // Narrow registers sit in the low bits; unknown codes read zero
   // Decoded from the live code so the answer is ready at the taking edge
   always @* begin
      case (cmd_code_i)
         `VOFR_CMD_OUT_FORMAT: read_mux = {8'h00, out_format_reg};
         `VOFR_CMD_TURN_ON:    read_mux = turn_on_reg;
         `VOFR_CMD_OV_LIMIT:   read_mux = ov_limit_reg;
         `VOFR_CMD_OV_ACTION:  read_mux = {8'h00, ov_action_reg};
         default:              read_mux = 16'h0000;
      endcase
   end

   // Answer one cycle after a read request, held until the next read
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_o  <= 16'h0000;
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= cmd_valid_i & ~cmd_write_i;
         if (cmd_valid_i & ~cmd_write_i)
            rdata_o <= read_mux;
      end
   end

   // -------------------------------------------------------------------
   // Format outputs
   // -------------------------------------------------------------------
   // Outputs lag the register by one edge, two edges after the command
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         format_mode_o  <= `VOFR_MODE_LINEAR;
         format_param_o <= `VOFR_PARAM_ZERO;
      end else begin
         format_mode_o  <= out_format_reg[`VOFR_FMT_MODE_HI:
                                          `VOFR_FMT_MODE_LO];
         format_param_o <= fmt_param(out_format_reg);
      end
   end

   // -------------------------------------------------------------------
   // Overvoltage status flag
   // -------------------------------------------------------------------
   // A fault in the clearing cycle survives: set wins over clear
   // Flag reports the event only; the response machine acts on ov_now
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i)
         ov_fault_o <= 1'b0;
      else if (ov_now)
         ov_fault_o <= 1'b1;
      else if (clear_cmd)
         ov_fault_o <= 1'b0;
   end

   // -------------------------------------------------------------------
   // Delay unit prescaler
   // -------------------------------------------------------------------
   // Free running while on; cleared on entry to wait so units are whole
   vofr_unit_timer #(
      .UNIT_CYCLES (UNIT_CYCLES),
      .CNT_W       (CNT_W)
   ) u_unit_timer (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .clear_i (timer_clear),
      .tick_o  (unit_tick)
   );

   // -------------------------------------------------------------------
   // Fault response machine
   // -------------------------------------------------------------------
   // Only response 10 shuts down; the reserved codes act as ignore so a
   // bad setting never turns the output off unexpectedly
   // used_reg counts restarts of one episode; only the off state or a
   // clear empties it, so a restart that trips again spends another
   always @* begin
      state_next  = state_reg;
      used_next   = used_reg;
      delay_next  = delay_reg;
      units_next  = units_reg;
      timer_clear = 1'b0;
      case (state_reg)
         ST_OFF: begin
            used_next   = 3'h0;
            timer_clear = 1'b1;
            if (other_fault_i)
               state_next = ST_LATCH;
            else if (on_request_i && vin_ready)
               state_next = ST_RUN;
         end
         ST_RUN: begin
            if (!on_request_i) begin
               state_next = ST_OFF;
            end else if (other_fault_i) begin
               state_next = ST_LATCH;
            end else if (ov_now && resp == `VOFR_RESP_DISABLE) begin
               if (retries == `VOFR_RETRY_NONE) begin
                  state_next = ST_LATCH;
               end else if (retries == `VOFR_RETRY_FOREVER) begin
                  state_next  = ST_WAIT;
                  delay_next  = delay_code;
                  units_next  = 3'h0;
                  timer_clear = 1'b1;
               end else if (used_reg < retries) begin
                  state_next  = ST_WAIT;
                  used_next   = used_reg + 3'h1;
                  delay_next  = delay_code;
                  units_next  = 3'h0;
                  timer_clear = 1'b1;
               end else begin
                  state_next = ST_LATCH;
               end
            end
            // Response 00 falls through and the output keeps running
         end
         ST_WAIT: begin
            if (!on_request_i) begin
               state_next = ST_OFF;
            end else if (other_fault_i) begin
               state_next = ST_LATCH;
            end else if (units_reg == delay_reg) begin
               state_next = ST_RUN;
            end else if (unit_tick) begin
               units_next = units_reg + 3'h1;
            end
         end
         ST_LATCH: begin
            // Held clear so no stale tick leaks into the next wait
            timer_clear = 1'b1;
            if (clear_cmd) begin
               state_next = ST_OFF;
               used_next  = 3'h0;
            end
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
   end

   // State registers of the response machine
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= ST_OFF;
         used_reg  <= 3'h0;
         delay_reg <= 3'h0;
         units_reg <= 3'h0;
      end else begin
         state_reg <= state_next;
         used_reg  <= used_next;
         delay_reg <= delay_next;
         units_reg <= units_next;
      end
   end

   // -------------------------------------------------------------------
   // Power stage outputs
   // -------------------------------------------------------------------
   // Registered from the next state so the enable drops in the same
   // edge that the machine leaves the run state
   // The restart count mirrors used_next so it moves with the enable
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         output_enable_o <= 1'b0;
         off_latched_o   <= 1'b0;
         restarts_used_o <= 3'h0;
      end else begin
         output_enable_o <= (state_next == ST_RUN);
         off_latched_o   <= (state_next == ST_LATCH);
         restarts_used_o <= used_next;
      end
   end

endmodule

/* dv/vofr_asserts.sv */
/* Checker for vofr_core: format outputs, overvoltage flag and restarts.
   Assumes it is bound to vofr_core and sees only its ports. */
`timescale 1ns/1ps
module vofr_asserts #(parameter int UNIT_CYCLES = 8) (
   input wire logic        clock_i,
   input wire logic        reset_i,
   input wire logic        cmd_valid_i,
   input wire logic        cmd_write_i,
   input wire logic [7:0]  cmd_code_i,
   input wire logic [15:0] cmd_wdata_i,
   input wire logic [15:0] vin_meas_i,
   input wire logic [15:0] vout_meas_i,
   input wire logic        on_request_i,
   input wire logic        other_fault_i,
   input wire logic [15:0] rdata_o,
   input wire logic        rvalid_o,
   input wire logic        output_enable_o,
   input wire logic        ov_fault_o,
   input wire logic        off_latched_o,
   input wire logic [2:0]  format_mode_o,
   input wire logic [4:0]  format_param_o,
   input wire logic [2:0]  restarts_used_o
);
   logic [15:0] lim_reg;
   logic [7:0]  act_reg;
   int          off_cnt_reg;
   wire         wr_w = cmd_valid_i && cmd_write_i;
   // Shadow limit and action; off time counted to time restarts
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         lim_reg <= 16'hffff;
         act_reg <= 8'h80;
         off_cnt_reg <= 0;
      end else begin
         if (wr_w && cmd_code_i == 8'h40) lim_reg <= cmd_wdata_i;
         if (wr_w && cmd_code_i == 8'h41) act_reg <= cmd_wdata_i[7:0];
         off_cnt_reg <= output_enable_o ? 0 : off_cnt_reg + 1;
      end
   end
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   sequence s_ov_seen;
      vout_meas_i > lim_reg;
   endsequence
   sequence s_fmt_wr;
      wr_w && cmd_code_i == 8'h20;
   endsequence
   a_fmt_mode_sel: assert property (s_fmt_wr |=> ##1
      format_mode_o == $past(cmd_wdata_i[7:5], 2)) else $error("mode");
   a_fmt_param_val: assert property (s_fmt_wr |=> ##1
      format_param_o == ($past(cmd_wdata_i[7:5], 2) == 3'h2 ? 5'h00 :
      $past(cmd_wdata_i[4:0], 2))) else $error("param");
   a_ov_strict: assert property ($rose(ov_fault_o) |->
      $past(vout_meas_i > lim_reg)) else $error("ov rose early");
   a_ov_equal_quiet: assert property (!ov_fault_o &&
      vout_meas_i <= lim_reg |=> !ov_fault_o) else $error("ov at limit");
   a_ignore_keeps_on: assert property (act_reg[7:6] == 2'b00 &&
      output_enable_o && on_request_i && !other_fault_i ##0 s_ov_seen
      |=> output_enable_o) else $error("ignore turned off");
   a_disable_on_trip: assert property (act_reg[7:6] == 2'b10 &&
      output_enable_o ##0 s_ov_seen |=> !output_enable_o && ov_fault_o)
      else $error("no trip");
   a_no_retry_off: assert property (act_reg[7:3] == 5'b10000 &&
      output_enable_o ##0 s_ov_seen |=> (!output_enable_o) [*8])
      else $error("retried");
   a_latched_stays_off: assert property (off_latched_o |->
      !output_enable_o) else $error("latched but on");
   a_retry_limit: assert property (act_reg[5:3] != 3'h7 |->
      restarts_used_o <= act_reg[5:3]) else $error("too many restarts");
   a_restart_gap: assert property ($rose(output_enable_o) &&
      restarts_used_o != 3'h0 |-> off_cnt_reg >= act_reg[2:0] * UNIT_CYCLES
      && off_cnt_reg <= act_reg[2:0] * UNIT_CYCLES + 4)
      else $error("restart spacing");
endmodule

/* dv/vofr_host_model.sv */
/* Host model: issues one command per call on the decoded command port.
   Assumes the same rising-edge clock as the block. */
`timescale 1ns/1ps
module vofr_host_model (
   input  wire logic  clock_i,
   output logic        cmd_valid_o,
   output logic        cmd_write_o,
   output logic [7:0]  cmd_code_o,
   output logic [15:0] cmd_wdata_o
);
   // Idle port until the first command
   initial begin
      cmd_valid_o = 1'b0;
      cmd_write_o = 1'b0;
      cmd_code_o = 8'h00;
      cmd_wdata_o = 16'h0000;
   end
   // Strobe held over exactly one taking edge, then dropped
   task automatic issue(input logic w, input logic [7:0] c,
                        input logic [15:0] d);
      @(posedge clock_i);
      #1;
      cmd_valid_o = 1'b1;
      cmd_write_o = w;
      cmd_code_o = c;
      cmd_wdata_o = d;
      @(posedge clock_i);
      #1;
      cmd_valid_o = 1'b0;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      issue(1'b1, c, d);
   endtask
   task automatic rd(input logic [7:0] c);
      issue(1'b0, c, 16'h0000);
   endtask
   task automatic clr;
      issue(1'b1, 8'h03, 16'h0000);
   endtask
   // Whole volts to mantissa with exponent -3
   task automatic wr_vin(input logic [15:0] v);
      issue(1'b1, 8'h35, v << 3);
   endtask
endmodule

/* dv/tb_vofr_core.sv */
/* Testbench for vofr_core: host model sends commands, bench drives
   measurements and on/off; reads go through an expected-value queue.
   Assumes a 50 MHz clock and a delay unit shortened to 8 cycles. */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
   fail_count++; $display("CHECK FAILED t=%0t got %h exp %h", $time, \
   g, e); end end
module tb_vofr_core;
   localparam int UNIT = 8;
   logic clock_i = 0, reset_i = 1, on_request_i = 0, other_fault_i = 0;
   logic [15:0] vin_meas_i = 0, vout_meas_i = 0, rdata_o, lim;
   logic cmd_valid_i, cmd_write_i, rvalid_o, output_enable_o, ov_fault_o;
   logic off_latched_o, p;
   logic [7:0] cmd_code_i;
   logic [15:0] cmd_wdata_i;
   logic [2:0] format_mode_o, restarts_used_o;
   logic [4:0] format_param_o;
   int fail_count = 0, total_checks = 0, seed = 32'h86a7, n, r, k;
   logic [15:0] exp_q[$];
   logic [15:0] exp_v;
   always #10 clock_i = ~clock_i;
   vofr_host_model vofr_host_model_i (.clock_i(clock_i),
      .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
      .cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i));
   vofr_core #(.UNIT_CYCLES(UNIT)) vofr_core_i (.clock_i(clock_i),
      .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
      .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i),
      .cmd_wdata_i(cmd_wdata_i), .vin_meas_i(vin_meas_i),
      .vout_meas_i(vout_meas_i), .on_request_i(on_request_i),
      .other_fault_i(other_fault_i), .rdata_o(rdata_o),
      .rvalid_o(rvalid_o), .output_enable_o(output_enable_o),
      .ov_fault_o(ov_fault_o), .off_latched_o(off_latched_o),
      .format_mode_o(format_mode_o), .format_param_o(format_param_o),
      .restarts_used_o(restarts_used_o));
   // Read answers taken mid-cycle, oldest note first
   always @(negedge clock_i) begin
      if (rvalid_o === 1'b1) begin
         // Pop once so a failing compare does not eat a second note
         exp_v = exp_q.pop_front();
         `CHK(rdata_o, exp_v)
      end
   end
   task automatic cyc(input int c);
      repeat (c) @(posedge clock_i);
      #1;
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      exp_q.push_back(e);
      vofr_host_model_i.rd(c);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Bounded wait on the enable; a stall ends the run
   task automatic wait_en(input logic v);
      n = 0;
      while (output_enable_o !== v && n < 600) begin
         cyc(1);
         n++;
      end
      if (output_enable_o !== v) begin
         fail_count++;
         $display("CHECK FAILED t=%0t enable stuck", $time);
         report_and_stop;
      end
   endtask
   initial begin
      lim = 16'h0100 + 16'($random(seed) & 32'h0fff);
      cyc(12);
      reset_i = 0;
      rd(8'h20, 16'h0000);
      rd(8'h35, 16'h0000);
      rd(8'h40, 16'hffff);
      rd(8'h41, 16'h0080);
      rd(8'h7e, 16'h0000);
      vofr_host_model_i.wr(8'h40, lim);
      rd(8'h40, lim);
      // Every format mode with a random parameter
      for (r = 0; r < 3; r++) begin
         n = $random(seed);
         vofr_host_model_i.wr(8'h20, {8'h00, r[2:0], n[4:0]});
         cyc(1);
         `CHK(format_mode_o, r[2:0])
         `CHK(format_param_o, r == 2 ? 5'h00 : n[4:0])
         rd(8'h20, {8'h00, r[2:0], n[4:0]});
      end
      $display("test registers done");
      vofr_host_model_i.wr_vin(16'd48);
      vin_meas_i = 16'd383;
      vout_meas_i = lim;
      on_request_i = 1;
      cyc(20);
      `CHK(output_enable_o, 1'b0)
      vin_meas_i = 16'd384;
      wait_en(1'b1);
      `CHK(output_enable_o, 1'b1)
      $display("test turn-on done");
      vofr_host_model_i.wr(8'h41, 16'h0000);
      cyc(5);
      `CHK(ov_fault_o, 1'b0)
      vout_meas_i = lim + 16'h0001;
      cyc(5);
      `CHK(ov_fault_o, 1'b1)
      `CHK(output_enable_o, 1'b1)
      vout_meas_i = lim;
      vofr_host_model_i.clr;
      `CHK(ov_fault_o, 1'b0)
      $display("test ignore done");
      // Every retry code under a standing overvoltage
      for (r = 0; r < 8; r++) begin
         vofr_host_model_i.wr(8'h41, 16'(8'h80 | (r << 3) | (r % 4)));
         vout_meas_i = lim + 16'h0001 + 16'($random(seed) & 32'h00ff);
         k = 0;
         p = output_enable_o;
         repeat (300) begin
            cyc(1);
            if (output_enable_o === 1'b1 && p !== 1'b1) k++;
            p = output_enable_o;
         end
         if (r < 7) begin
            `CHK(k, r)
            `CHK(off_latched_o, 1'b1)
            `CHK(restarts_used_o, r[2:0])
         end else begin
            `CHK(k > 5, 1'b1)
            on_request_i = 0;
            cyc(2);
            `CHK(output_enable_o, 1'b0)
            on_request_i = 1;
         end
         vout_meas_i = lim;
         vofr_host_model_i.clr;
         wait_en(1'b1);
         `CHK(restarts_used_o, 3'h0)
         $display("test retry code %0d done", r);
      end
      other_fault_i = 1;
      cyc(3);
      `CHK(off_latched_o, 1'b1)
      other_fault_i = 0;
      vofr_host_model_i.clr;
      wait_en(1'b1);
      `CHK(exp_q.size(), 0)
      $display("test other fault done");
      report_and_stop;
   end
endmodule
bind vofr_core vofr_asserts #(.UNIT_CYCLES(UNIT_CYCLES)) vofr_asserts_i (
   .clock_i(clock_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
   .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i),
   .cmd_wdata_i(cmd_wdata_i), .vin_meas_i(vin_meas_i),
   .vout_meas_i(vout_meas_i), .on_request_i(on_request_i),
   .other_fault_i(other_fault_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
   .output_enable_o(output_enable_o), .ov_fault_o(ov_fault_o),
   .off_latched_o(off_latched_o), .format_mode_o(format_mode_o),
   .format_param_o(format_param_o), .restarts_used_o(restarts_used_o));
